// File: rtl/mort_pkg.sv
// Package with register map, field layout and reset values of the oscillator trim block
package mort_pkg;
	// ----------------------------------------
	// Register byte addresses (printed offsets not all multiples of four: index * 4)
	// ----------------------------------------
	localparam logic [7:0]  IDX_COARSE_TRIM  = 8'hE8;
	localparam logic [7:0]  IDX_FINE_TRIM    = 8'hFA;
	localparam logic [7:0]  IDX_SCR_ONE      = 8'hFE;
	localparam logic [7:0]  IDX_CLOCK_CTRL   = 8'hE2;
	localparam logic [7:0]  IDX_TRIM_STATUS  = 8'hF0;
	localparam logic [11:0] ADDR_COARSE_TRIM = {2'b00, IDX_COARSE_TRIM, 2'b00};
	localparam logic [11:0] ADDR_FINE_TRIM   = {2'b00, IDX_FINE_TRIM, 2'b00};
	localparam logic [11:0] ADDR_SCR_ONE     = {2'b00, IDX_SCR_ONE, 2'b00};
	localparam logic [11:0] ADDR_CLOCK_CTRL  = {2'b00, IDX_CLOCK_CTRL, 2'b00};
	localparam logic [11:0] ADDR_TRIM_STATUS = {2'b00, IDX_TRIM_STATUS, 2'b00};
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SCR_RAM_INIT_BIT    = 0;
	localparam int SCR_RANGE_LO        = 3;
	localparam int SCR_RANGE_HI        = 4;
	localparam int SCR_BOOT_REPEAT_BIT = 7;
	localparam int FINE_HI             = 2;
	localparam int CTRL_EXT_CLK_BIT    = 2;
	localparam int CTRL_DOUBLER_EN_BIT = 0;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_COARSE_TRIM = 8'h00;
	localparam logic [2:0] RST_FINE_TRIM   = 3'h0;
	localparam logic [1:0] RST_RANGE       = 2'h0;
	localparam logic       RST_RAM_INIT    = 1'b0;
	localparam logic       RST_EXT_CLK     = 1'b0;
	localparam logic       RST_DOUBLER_EN  = 1'b1;
	// ----------------------------------------
	// Range codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		MORT_RANGE_12MHZ = 2'h0,
		MORT_RANGE_6MHZ  = 2'h1,
		MORT_RANGE_24MHZ = 2'h2,
		MORT_RANGE_RSVD  = 2'h3
	} mort_range_t;
endpackage

// File: rtl/mort_osc_ctrl.sv
// Main oscillator range and trim control with APB register access
`timescale 1ns/1ns
module mort_osc_ctrl
	import mort_pkg::*;
#(
	parameter logic [7:0] FACTORY_COARSE_TRIM = 8'h80
) (
	input  wire logic        i_clock,
	input  wire logic        i_reset,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	input  wire logic        i_usb_lock_enable,
	input  wire logic        i_boot_repeat,
	input  wire logic        i_boot_done,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic      [1:0]  o_osc_range_select,
	output logic      [10:0] o_trim_word,
	output logic             o_system_clock_net_from_osc,
	output logic             o_doubler_enable,
	output logic             o_ram_init_reduce,
	output logic             o_boot_repeat_flag
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0]  coarse_q, coarse_d;
	logic [2:0]  fine_q, fine_d;
	logic [1:0]  range_q, range_d;
	logic        ram_red_q, ram_red_d;
	logic        ext_clk_q, ext_clk_d;
	logic        dbl_en_q, dbl_en_d;
	logic        boot_rep_q, boot_rep_d;
	logic        booted_q, booted_d;
	logic        fine_drop_q, fine_drop_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic [10:0] trim_q, trim_d;
	logic        src_osc_q, src_osc_d;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic wr_acc;
	logic rd_acc;
	logic hit;
	assign wr_acc = i_psel && i_penable && i_pwrite && !pready_q;
	assign rd_acc = i_psel && i_penable && !i_pwrite && !pready_q;
	always_comb begin
		case (i_paddr)
			ADDR_COARSE_TRIM,
			ADDR_FINE_TRIM,
			ADDR_SCR_ONE,
			ADDR_CLOCK_CTRL,
			ADDR_TRIM_STATUS: hit = 1'b1;
			default:          hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		coarse_d    = coarse_q;
		fine_d      = fine_q;
		range_d     = range_q;
		ram_red_d   = ram_red_q;
		ext_clk_d   = ext_clk_q;
		dbl_en_d    = dbl_en_q;
		boot_rep_d  = boot_rep_q;
		booted_d    = booted_q;
		fine_drop_d = fine_drop_q;
		prdata_d    = 32'h0000_0000;
		pready_d    = i_psel && i_penable && !pready_q;
		pslverr_d   = i_psel && i_penable && !pready_q && !hit;
		// Factory trim and boot status captured once the boot routine ends
		if (i_boot_done && !booted_q) begin
			booted_d   = 1'b1;
			coarse_d   = FACTORY_COARSE_TRIM;
			boot_rep_d = i_boot_repeat;
		end
		if (wr_acc && i_pstrb[0]) begin
			case (i_paddr)
				ADDR_COARSE_TRIM: coarse_d = i_pwdata[7:0];
				ADDR_FINE_TRIM: begin
					if (i_usb_lock_enable) begin
						fine_drop_d = 1'b1;
					end else begin
						fine_d = i_pwdata[FINE_HI:0];
					end
				end
				ADDR_SCR_ONE: begin
					range_d   = i_pwdata[SCR_RANGE_HI:SCR_RANGE_LO];
					ram_red_d = i_pwdata[SCR_RAM_INIT_BIT];
				end
				ADDR_CLOCK_CTRL: begin
					ext_clk_d = i_pwdata[CTRL_EXT_CLK_BIT];
					dbl_en_d  = i_pwdata[CTRL_DOUBLER_EN_BIT];
				end
				ADDR_TRIM_STATUS: begin
					if (i_pwdata[0]) begin
						fine_drop_d = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (rd_acc) begin
			case (i_paddr)
				ADDR_COARSE_TRIM: prdata_d = {24'h000000, coarse_q};
				ADDR_FINE_TRIM:   prdata_d = {29'h00000000, fine_q};
				ADDR_SCR_ONE:     prdata_d = {24'h000000, boot_rep_q, 2'b00, range_q, 2'b00, ram_red_q};
				ADDR_CLOCK_CTRL:  prdata_d = {29'h00000000, ext_clk_q, 1'b0, dbl_en_q};
				ADDR_TRIM_STATUS: prdata_d = {31'h00000000, fine_drop_q};
				default:          prdata_d = 32'h0000_0000;
			endcase
		end
		// Register outputs are loaded from the next state, so they change on the same edge as the stored state
		trim_d    = {coarse_d, fine_d};
		src_osc_d = !ext_clk_d;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			coarse_q    <= RST_COARSE_TRIM;
			fine_q      <= RST_FINE_TRIM;
			range_q     <= RST_RANGE;
			ram_red_q   <= RST_RAM_INIT;
			ext_clk_q   <= RST_EXT_CLK;
			dbl_en_q    <= RST_DOUBLER_EN;
			boot_rep_q  <= 1'b0;
			booted_q    <= 1'b0;
			fine_drop_q <= 1'b0;
			prdata_q    <= 32'h0000_0000;
			pready_q    <= 1'b0;
			pslverr_q   <= 1'b0;
			trim_q      <= {RST_COARSE_TRIM, RST_FINE_TRIM};
			src_osc_q   <= !RST_EXT_CLK;
		end else begin
			coarse_q    <= coarse_d;
			fine_q      <= fine_d;
			range_q     <= range_d;
			ram_red_q   <= ram_red_d;
			ext_clk_q   <= ext_clk_d;
			dbl_en_q    <= dbl_en_d;
			boot_rep_q  <= boot_rep_d;
			booted_q    <= booted_d;
			fine_drop_q <= fine_drop_d;
			prdata_q    <= prdata_d;
			pready_q    <= pready_d;
			pslverr_q   <= pslverr_d;
			trim_q      <= trim_d;
			src_osc_q   <= src_osc_d;
		end
	end

	assign o_prdata           = prdata_q;
	assign o_pready           = pready_q;
	assign o_pslverr          = pslverr_q;
	assign o_osc_range_select = range_q;
	assign o_trim_word        = trim_q;
	assign o_system_clock_net_from_osc  = src_osc_q;
	assign o_doubler_enable   = dbl_en_q;
	assign o_ram_init_reduce  = ram_red_q;
	assign o_boot_repeat_flag = boot_rep_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_range_write;
		@(posedge i_clock) disable iff (i_reset)
		(wr_acc && i_pstrb[0] && i_paddr == ADDR_SCR_ONE) |=> (o_osc_range_select == $past(i_pwdata[4:3]));
	endproperty
	a_range_write: assert property (p_range_write) else $error("range not updated");
	property p_range_hold;
		@(posedge i_clock) disable iff (i_reset)
		!(wr_acc && i_paddr == ADDR_SCR_ONE) |=> $stable(o_osc_range_select);
	endproperty
	a_range_hold: assert property (p_range_hold) else $error("range changed without write");
	property p_fine_locked;
		@(posedge i_clock) disable iff (i_reset)
		(wr_acc && i_paddr == ADDR_FINE_TRIM && i_usb_lock_enable) |=> ##1 $stable(o_trim_word[2:0]);
	endproperty
	a_fine_locked: assert property (p_fine_locked) else $error("fine trim written under lock");
	property p_fine_write;
		@(posedge i_clock) disable iff (i_reset)
		(wr_acc && i_pstrb[0] && i_paddr == ADDR_FINE_TRIM && !i_usb_lock_enable) |=> ##1 (o_trim_word[2:0] == $past(i_pwdata[2:0], 2));
	endproperty
	a_fine_write: assert property (p_fine_write) else $error("fine trim not in low bits");
	property p_coarse_write;
		@(posedge i_clock) disable iff (i_reset)
		(wr_acc && i_pstrb[0] && i_paddr == ADDR_COARSE_TRIM) |=> ##1 (o_trim_word[10:3] == $past(i_pwdata[7:0], 2));
	endproperty
	a_coarse_write: assert property (p_coarse_write) else $error("coarse trim not in high bits");
	property p_boot_load;
		@(posedge i_clock) disable iff (i_reset)
		(i_boot_done && !booted_q && !(wr_acc && i_paddr == ADDR_COARSE_TRIM)) |=> ##1 (o_trim_word[10:3] == FACTORY_COARSE_TRIM);
	endproperty
	a_boot_load: assert property (p_boot_load) else $error("factory trim not loaded");
	property p_system_clock_net_src;
		@(posedge i_clock) disable iff (i_reset)
		(wr_acc && i_pstrb[0] && i_paddr == ADDR_CLOCK_CTRL) |=> ##1 (o_system_clock_net_from_osc == !$past(i_pwdata[2], 2));
	endproperty
	a_system_clock_net_src: assert property (p_system_clock_net_src) else $error("clock source wrong");
	property p_boot_flag_ro;
		@(posedge i_clock) disable iff (i_reset)
		booted_q |=> $stable(o_boot_repeat_flag);
	endproperty
	a_boot_flag_ro: assert property (p_boot_flag_ro) else $error("boot flag changed");
	property p_scr_read;
		@(posedge i_clock) disable iff (i_reset)
		(rd_acc && i_paddr == ADDR_SCR_ONE) |=> (o_pready && o_prdata[7] == o_boot_repeat_flag && o_prdata[0] == o_ram_init_reduce);
	endproperty
	a_scr_read: assert property (p_scr_read) else $error("register one read wrong");
	property p_pready_pulse;
		@(posedge i_clock) disable iff (i_reset)
		o_pready |=> !o_pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse) else $error("ready held too long");
	property p_slverr_with_ready;
		@(posedge i_clock) disable iff (i_reset)
		o_pslverr |-> o_pready;
	endproperty
	a_slverr_with_ready: assert property (p_slverr_with_ready) else $error("error without ready");
	property p_unmapped_err;
		@(posedge i_clock) disable iff (i_reset)
		(i_psel && i_penable && !pready_q && !hit) |=> o_pslverr;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");
	property p_prdata_idle;
		@(posedge i_clock) disable iff (i_reset)
		!o_pready |-> (o_prdata == 32'h0000_0000);
	endproperty
	a_prdata_idle: assert property (p_prdata_idle) else $error("read data outside answer");
	property p_coarse_read;
		@(posedge i_clock) disable iff (i_reset)
		(rd_acc && i_paddr == ADDR_COARSE_TRIM) |=> (o_prdata == {24'h000000, $past(o_trim_word[10:3])});
	endproperty
	a_coarse_read: assert property (p_coarse_read) else $error("coarse trim read wrong");
	property p_fine_read;
		@(posedge i_clock) disable iff (i_reset)
		(rd_acc && i_paddr == ADDR_FINE_TRIM) |=> (o_prdata == {29'h00000000, $past(o_trim_word[2:0])});
	endproperty
	a_fine_read: assert property (p_fine_read) else $error("fine trim read wrong");
	property p_ram_write;
		@(posedge i_clock) disable iff (i_reset)
		(wr_acc && i_pstrb[0] && i_paddr == ADDR_SCR_ONE) |=> (o_ram_init_reduce == $past(i_pwdata[0]));
	endproperty
	a_ram_write: assert property (p_ram_write) else $error("ram init bit not written");
	property p_doubler_write;
		@(posedge i_clock) disable iff (i_reset)
		(wr_acc && i_pstrb[0] && i_paddr == ADDR_CLOCK_CTRL) |=> (o_doubler_enable == $past(i_pwdata[0]));
	endproperty
	a_doubler_write: assert property (p_doubler_write) else $error("doubler enable not written");
	property p_drop_set;
		@(posedge i_clock) disable iff (i_reset)
		(wr_acc && i_pstrb[0] && i_paddr == ADDR_FINE_TRIM && i_usb_lock_enable) |=> fine_drop_q;
	endproperty
	a_drop_set: assert property (p_drop_set) else $error("dropped fine write not flagged");
	property p_reset_vals;
		@(posedge i_clock)
		i_reset |=> (o_doubler_enable && o_system_clock_net_from_osc && o_trim_word == 11'h000 && !o_ram_init_reduce);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
	property p_system_clock_net_follow;
		@(posedge i_clock) disable iff (i_reset)
		o_system_clock_net_from_osc == !ext_clk_q;
	endproperty
	a_system_clock_net_follow: assert property (p_system_clock_net_follow) else $error("clock source mismatch");
	property p_trim_concat;
		@(posedge i_clock) disable iff (i_reset)
		o_trim_word == {coarse_q, fine_q};
	endproperty
	a_trim_concat: assert property (p_trim_concat) else $error("trim word not coarse over fine");
	property p_boot_once;
		@(posedge i_clock) disable iff (i_reset)
		(booted_q && !(wr_acc && i_paddr == ADDR_COARSE_TRIM)) |=> $stable(o_trim_word[10:3]);
	endproperty
	a_boot_once: assert property (p_boot_once) else $error("coarse trim reloaded");
	property p_scr_reserved;
		@(posedge i_clock) disable iff (i_reset)
		(rd_acc && i_paddr == ADDR_SCR_ONE) |=> (o_prdata[31:8] == 24'h000000 && o_prdata[6:5] == 2'h0 && o_prdata[2:1] == 2'h0);
	endproperty
	a_scr_reserved: assert property (p_scr_reserved) else $error("reserved bits not zero");
endmodule

// File: testbench/main_oscillator_range_trim_bench.sv
// Self-checking bench for the oscillator range and trim block
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module main_oscillator_range_trim_bench
	import mort_pkg::*;
;
	localparam logic [7:0] FCT = 8'h5A;
	logic        i_clock, i_reset, i_psel, i_penable, i_pwrite;
	logic        i_usb_lock_enable, i_boot_repeat, i_boot_done;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, v;
	logic [3:0]  i_pstrb;
	logic        o_pready, o_pslverr, o_system_clock_net_from_osc, o_doubler_enable;
	logic        o_ram_init_reduce, o_boot_repeat_flag, e;
	logic [1:0]  o_osc_range_select;
	logic [10:0] o_trim_word;
	int          n_mismatch, comparisons;
	mort_range_t codes [3] = '{MORT_RANGE_12MHZ, MORT_RANGE_6MHZ, MORT_RANGE_24MHZ};

	mort_osc_ctrl #(.FACTORY_COARSE_TRIM(FCT)) u_dut (.i_clock, .i_reset, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .i_pstrb, .i_usb_lock_enable, .i_boot_repeat, .i_boot_done, .o_prdata, .o_pready,
		.o_pslverr, .o_osc_range_select, .o_trim_word, .o_system_clock_net_from_osc, .o_doubler_enable,
		.o_ram_init_reduce, .o_boot_repeat_flag);

	// ----------------------------------------
	// APB master
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge i_clock);
		i_psel    <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite  <= wr;
		i_paddr   <= a;
		i_pwdata  <= {24'h000000, d};
		@(posedge i_clock);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		if (n >= 20) n_mismatch++;
		v = o_prdata;
		e = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic settle();
		repeat (2) @(posedge i_clock);
		#1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		apb(0, ADDR_SCR_ONE, 8'h00);
		`CHK(v, 32'h00000000)
		`CHK(e, 1'b0)
		`CHK(o_doubler_enable, 1'b1)
		`CHK(o_system_clock_net_from_osc, 1'b1)
		$display("test reset done");
	endtask
	task automatic t_boot();
		@(posedge i_clock);
		i_boot_repeat <= 1'b1;
		i_boot_done   <= 1'b1;
		@(posedge i_clock);
		i_boot_done   <= 1'b0;
		i_boot_repeat <= 1'b0;
		settle();
		`CHK(o_trim_word, {FCT, 3'h0})
		`CHK(o_boot_repeat_flag, 1'b1)
		apb(1, ADDR_SCR_ONE, 8'h00);
		apb(0, ADDR_SCR_ONE, 8'h00);
		`CHK(v[7:0], 8'h80)
		$display("test boot done");
	endtask
	task automatic t_range();
		for (int k = 0; k < 3; k++) begin
			apb(1, ADDR_SCR_ONE, {3'h0, codes[k], 3'h0});
			#1;
			`CHK(o_osc_range_select, codes[k])
			apb(0, ADDR_SCR_ONE, 8'h00);
			`CHK(v[4:3], codes[k])
		end
		apb(1, ADDR_SCR_ONE, 8'h09);
		#1;
		`CHK(o_ram_init_reduce, 1'b1)
		`CHK(o_osc_range_select, MORT_RANGE_6MHZ)
		apb(1, ADDR_COARSE_TRIM, FCT);
		apb(0, ADDR_COARSE_TRIM, 8'h00);
		`CHK(v, {24'h000000, FCT})
		$display("test range done");
	endtask
	task automatic t_trim();
		apb(1, ADDR_COARSE_TRIM, 8'hA5);
		apb(1, ADDR_FINE_TRIM, 8'h06);
		apb(0, ADDR_COARSE_TRIM, 8'h00);
		`CHK(v, 32'h000000A5)
		settle();
		`CHK(o_trim_word, 11'h52E)
		@(posedge i_clock);
		i_usb_lock_enable <= 1'b1;
		apb(1, ADDR_FINE_TRIM, 8'h07);
		apb(0, ADDR_FINE_TRIM, 8'h00);
		`CHK(v[2:0], 3'h6)
		apb(0, ADDR_TRIM_STATUS, 8'h00);
		`CHK(v, 32'h00000001)
		apb(1, ADDR_TRIM_STATUS, 8'h01);
		apb(0, ADDR_TRIM_STATUS, 8'h00);
		`CHK(v, 32'h00000000)
		i_usb_lock_enable <= 1'b0;
		apb(1, ADDR_FINE_TRIM, 8'h07);
		settle();
		`CHK(o_trim_word, 11'h52F)
		$display("test trim done");
	endtask
	task automatic t_clock();
		apb(1, ADDR_CLOCK_CTRL, 8'h04);
		settle();
		`CHK(o_system_clock_net_from_osc, 1'b0)
		`CHK(o_doubler_enable, 1'b0)
		apb(1, ADDR_CLOCK_CTRL, 8'h01);
		settle();
		`CHK(o_system_clock_net_from_osc, 1'b1)
		`CHK(o_doubler_enable, 1'b1)
		apb(0, 12'h004, 8'h00);
		`CHK(e, 1'b1)
		`CHK(v, 32'h00000000)
		$display("test clock done");
	endtask
	task automatic t_rereset();
		@(posedge i_clock);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_reset <= 1'b0;
		#1;
		`CHK(o_trim_word, 11'h000)
		`CHK(o_boot_repeat_flag, 1'b0)
		`CHK(o_doubler_enable, 1'b1)
		`CHK(o_system_clock_net_from_osc, 1'b1)
		`CHK(o_ram_init_reduce, 1'b0)
		`CHK(o_osc_range_select, MORT_RANGE_12MHZ)
		@(posedge i_clock);
		i_boot_done <= 1'b1;
		@(posedge i_clock);
		i_boot_done <= 1'b0;
		settle();
		`CHK(o_trim_word, {FCT, 3'h0})
		`CHK(o_boot_repeat_flag, 1'b0)
		$display("test second reset done");
	endtask

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		i_clock = 0;
		forever #50 i_clock = ~i_clock;
	end
	initial begin
		#500000;
		n_mismatch++;
		summarize();
	end
	initial begin
		{i_psel, i_penable, i_pwrite, i_usb_lock_enable, i_boot_repeat, i_boot_done} = '0;
		i_paddr  = '0;
		i_pwdata = '0;
		i_pstrb  = 4'hF;
		i_reset  = 1'b1;
		repeat (4) @(posedge i_clock);
		i_reset <= 1'b0;
		t_reset();
		t_boot();
		t_range();
		t_trim();
		t_clock();
		t_rereset();
		summarize();
	end
endmodule
